//--- ctefq_ctrl.sv
// control and status of the transmit event queue: register port,
// depth and stamp configuration, flush, tail advance and interrupts
// assumes the transmit engine raises event_req_i for one cycle per
// completed transmission that asks for an event, and that a message
// memory writer consumes evt_wr_o
//
// How it works
// - depth code plus one gives capacity
// - depth and stamp writable only in configuration
// - flush bit resets queue, self-clears, resets one
// - tail advance write moves tail one entry
// - stamp enable selects stamped entries
// - four enable bits gate interrupt requests
// - overflow flag sticky until software clears
// - full flag follows all entries occupied
// - half flag follows occupancy at least half
// - not-empty flag follows occupancy above zero
// - occupancy flags read-only, follow occupancy
// - unimplemented bits read zero, ignore writes
`timescale 1ns/1ps
`include "ctefq_map.svh"

module ctefq_ctrl (
  // clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     arst_n_i,
  // register port
  input  wire logic [`CTEFQ_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`CTEFQ_DATA_W-1:0] reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [`CTEFQ_DATA_W-1:0] reg_rdata_o,
  // controller mode and transmit engine
  input  wire logic [`CTEFQ_MODE_W-1:0] operating_mode_select_i,
  input  wire logic                     event_req_i,
  // message memory side
  output ctefq_pkg::ctefq_evt_t         evt_wr_o,
  output logic      [`CTEFQ_IDX_W-1:0]  event_read_pointer_o,
  output logic                          stamp_enable_o,
  output logic                          queue_flush_o,
  // interrupt
  output logic                          irq_o
);

  ctefq_pkg::ctefq_cfg_t      cfg;
  ctefq_pkg::ctefq_occ_t      occ;
  ctefq_pkg::ctefq_occ_t      occ_q;
  logic                       queue_flush;
  logic                       overflow_flag;
  logic [`CTEFQ_IRQ_W-1:0]    pending;
  logic [`CTEFQ_IDX_W-1:0]    head;
  logic [`CTEFQ_IDX_W-1:0]    tail;
  logic [`CTEFQ_CNT_W-1:0]    count;

  logic                       in_config;
  logic                       wr_ctl;
  logic                       wr_sta;
  logic                       wr_pend;
  logic                       tail_advance;
  logic                       event_push;
  logic                       overflow_evt;
  logic [`CTEFQ_IRQ_W-1:0]    pend_set;
  logic [`CTEFQ_IRQ_W-1:0]    pend_clr;
  logic [`CTEFQ_IRQ_W-1:0]    next_pending;
  logic [`CTEFQ_DATA_W-1:0]   ctl_word;
  logic [`CTEFQ_DATA_W-1:0]   sta_word;
  logic [`CTEFQ_DATA_W-1:0]   pend_word;
  logic [`CTEFQ_DATA_W-1:0]   next_rdata;

  // decode
  assign in_config = (operating_mode_select_i == `CTEFQ_MODE_CONFIG);
  assign wr_ctl    = reg_wr_i && (reg_addr_i == `CTEFQ_OFF_CTL);
  assign wr_sta    = reg_wr_i && (reg_addr_i == `CTEFQ_OFF_STA);
  assign wr_pend   = reg_wr_i && (reg_addr_i == `CTEFQ_OFF_PEND);

  // tail advance commands are ignored while a flush is pending, so a stale advance
  // cannot move the tail off the freshly cleared base entry
  assign tail_advance = wr_ctl && reg_wdata_i[`CTEFQ_TAIL_BIT]
                        && !queue_flush && occ.nonempty;
  assign event_push   = event_req_i && !queue_flush
                        && !occ.full;
  assign overflow_evt = event_req_i && !queue_flush
                        && occ.full;

  // queue pointers
  // events met while a flush is pending are dropped, not counted as
  // overflows, since the queue is being emptied anyway
  ctefq_ptr ctefq_ptr_i (
    .sys_clk_i    (sys_clk_i),
    .arst_n_i     (arst_n_i),
    .depth_code_i (cfg.depth_code),
    .flush_i      (queue_flush),
    .push_i       (event_push),
    .pop_i        (tail_advance),
    .head_o       (head),
    .tail_o       (tail),
    .count_o      (count),
    .occ_o        (occ)
  );

  // configuration fields
  // a depth change with entries stored is not guarded; software is
  // expected to change it only in configuration with a flush after
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg.depth_code   <= `CTEFQ_DEPTH_RST;
      cfg.stamp_enable <= 1'b0;
    end
    else if (wr_ctl && in_config)
    begin
      cfg.depth_code   <= reg_wdata_i[`CTEFQ_DEPTH_MSB:`CTEFQ_DEPTH_LSB];
      cfg.stamp_enable <= reg_wdata_i[`CTEFQ_STAMP_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg.irq_enable <= `CTEFQ_IRQ_RST;
    end
    else if (wr_ctl)
    begin
      cfg.irq_enable <= reg_wdata_i[`CTEFQ_IRQ_W-1:0];
    end
  end

  // flush: set by software, cleared once the pointers are at base
  // and the controller has left configuration
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      queue_flush <= `CTEFQ_FLUSH_RST;
    end
    else if (wr_ctl && reg_wdata_i[`CTEFQ_FLUSH_BIT])
    begin
      queue_flush <= 1'b1;
    end
    else if (queue_flush && !in_config)
    begin
      queue_flush <= 1'b0;
    end
  end

  // overflow flag: hardware set wins over a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      overflow_flag <= 1'b0;
    end
    else if (overflow_evt)
    begin
      overflow_flag <= 1'b1;
    end
    else if (wr_sta && reg_wdata_i[`CTEFQ_OVF_BIT])
    begin
      overflow_flag <= 1'b0;
    end
  end

  // interrupt pending: sticky, write one to clear, set wins
  // occ_q keeps last cycle's occupancy for the edge detectors; its
  // reset value matches an empty queue, so no false edge follows reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      occ_q <= '0;
    end
    else
    begin
      occ_q <= occ;
    end
  end

  // occupancy flags raise a pending bit on their rising edge only, so
  // a queue that stays full does not re-arm after software clears it
  assign pend_set[`CTEFQ_OVF_BIT]  = overflow_evt;
  assign pend_set[`CTEFQ_FULL_BIT] = occ.full & ~occ_q.full;
  assign pend_set[`CTEFQ_HALF_BIT] = occ.half & ~occ_q.half;
  assign pend_set[`CTEFQ_NE_BIT]   = occ.nonempty & ~occ_q.nonempty;
  assign pend_clr = wr_pend ? reg_wdata_i[`CTEFQ_IRQ_W-1:0]
                            : `CTEFQ_IRQ_RST;
  assign next_pending = (pending & ~pend_clr) | pend_set;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pending <= `CTEFQ_IRQ_RST;
    end
    else
    begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(next_pending & cfg.irq_enable);
    end
  end

  // read path; tail advance and unimplemented bits read zero
  // read data fall back to zero between answers, so a stale word is
  // never mistaken for a fresh one
  always_comb
  begin
    ctl_word = `CTEFQ_WORD_ZERO;
    ctl_word[`CTEFQ_DEPTH_MSB:`CTEFQ_DEPTH_LSB] = cfg.depth_code;
    ctl_word[`CTEFQ_FLUSH_BIT] = queue_flush;
    ctl_word[`CTEFQ_STAMP_BIT] = cfg.stamp_enable;
    ctl_word[`CTEFQ_IRQ_W-1:0] = cfg.irq_enable;
  end

  always_comb
  begin
    sta_word = `CTEFQ_WORD_ZERO;
    sta_word[`CTEFQ_OVF_BIT]  = overflow_flag;
    sta_word[`CTEFQ_FULL_BIT] = occ.full;
    sta_word[`CTEFQ_HALF_BIT] = occ.half;
    sta_word[`CTEFQ_NE_BIT]   = occ.nonempty;
  end

  always_comb
  begin
    pend_word = `CTEFQ_WORD_ZERO;
    pend_word[`CTEFQ_IRQ_W-1:0] = pending;
  end

  always_comb
  begin
    next_rdata = `CTEFQ_WORD_ZERO;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `CTEFQ_OFF_CTL:  next_rdata = ctl_word;
        `CTEFQ_OFF_STA:  next_rdata = sta_word;
        `CTEFQ_OFF_PEND: next_rdata = pend_word;
        default:         next_rdata = `CTEFQ_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_o <= `CTEFQ_WORD_ZERO;
    end
    else
    begin
      reg_rdata_o <= next_rdata;
    end
  end

  // message memory side; the index is the head slot before it advances
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      evt_wr_o <= '0;
    end
    else
    begin
      evt_wr_o.valid <= event_push;
      evt_wr_o.index <= head;
      evt_wr_o.stamp <= cfg.stamp_enable;
    end
  end

  // software reads the entry at this index, then advances the tail
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      event_read_pointer_o <= `CTEFQ_IDX_ZERO;
      stamp_enable_o       <= 1'b0;
      queue_flush_o        <= `CTEFQ_FLUSH_RST;
    end
    else
    begin
      event_read_pointer_o <= tail;
      stamp_enable_o       <= cfg.stamp_enable;
      queue_flush_o        <= queue_flush;
    end
  end

endmodule : ctefq_ctrl

//--- ctefq_map.svh
// register map, field positions and codes of the transmit event queue
// control logic; included by the package and by the design modules
`ifndef CTEFQ_MAP_SVH
`define CTEFQ_MAP_SVH

// register bus geometry
`define CTEFQ_ADDR_W        8
`define CTEFQ_DATA_W        32

// register byte offsets
`define CTEFQ_OFF_CTL       8'h00
`define CTEFQ_OFF_STA       8'h04
`define CTEFQ_OFF_PEND      8'h08

// control register fields
`define CTEFQ_DEPTH_MSB     28
`define CTEFQ_DEPTH_LSB     24
`define CTEFQ_FLUSH_BIT     10
`define CTEFQ_TAIL_BIT      8
`define CTEFQ_STAMP_BIT     5

// status, pending and enable layout (shared)
`define CTEFQ_OVF_BIT       3
`define CTEFQ_FULL_BIT      2
`define CTEFQ_HALF_BIT      1
`define CTEFQ_NE_BIT        0
`define CTEFQ_IRQ_W         4

// queue geometry
`define CTEFQ_IDX_W         5
`define CTEFQ_CNT_W         6
`define CTEFQ_CNT_ONE       6'h01
`define CTEFQ_IDX_ZERO      5'h00
`define CTEFQ_IDX_ONE       5'h01
`define CTEFQ_CNT_ZERO      6'h00

// operating mode codes
`define CTEFQ_MODE_W        3
`define CTEFQ_MODE_CONFIG   3'h4

// reset values
`define CTEFQ_FLUSH_RST     1'b1
`define CTEFQ_DEPTH_RST     5'h00
`define CTEFQ_IRQ_RST       4'h0
`define CTEFQ_WORD_ZERO     32'h0000_0000

`endif

//--- ctefq_pkg.sv
// types shared by the transmit event queue control modules
// assumes ctefq_map.svh sits in the include path
`include "ctefq_map.svh"

package ctefq_pkg;

  // software-visible configuration held in the control register
  typedef struct packed {
    logic [`CTEFQ_IDX_W-1:0] depth_code;
    logic                    stamp_enable;
    logic [`CTEFQ_IRQ_W-1:0] irq_enable;
  } ctefq_cfg_t;

  // one accepted event, handed to the message memory writer
  typedef struct packed {
    logic                    valid;
    logic [`CTEFQ_IDX_W-1:0] index;
    logic                    stamp;
  } ctefq_evt_t;

  // occupancy view of the queue
  typedef struct packed {
    logic full;
    logic half;
    logic nonempty;
  } ctefq_occ_t;

endpackage : ctefq_pkg

//--- ctefq_ptr.sv
// head, tail and occupancy tracking of the transmit event queue
// assumes the caller only pushes/pops under its own admission checks;
// pushes on a full queue and pops on an empty one are dropped here too
`timescale 1ns/1ps
`include "ctefq_map.svh"

module ctefq_ptr (
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    arst_n_i,
  // configuration and commands
  input  wire logic [`CTEFQ_IDX_W-1:0] depth_code_i,
  input  wire logic                    flush_i,
  input  wire logic                    push_i,
  input  wire logic                    pop_i,
  // queue state
  output logic      [`CTEFQ_IDX_W-1:0] head_o,
  output logic      [`CTEFQ_IDX_W-1:0] tail_o,
  output logic      [`CTEFQ_CNT_W-1:0] count_o,
  output ctefq_pkg::ctefq_occ_t        occ_o
);

  logic [`CTEFQ_CNT_W-1:0] depth;
  logic                    do_push;
  logic                    do_pop;
  logic [`CTEFQ_IDX_W-1:0] next_head;
  logic [`CTEFQ_IDX_W-1:0] next_tail;

  // capacity is the code plus one entry
  assign depth = {1'b0, depth_code_i} + `CTEFQ_CNT_ONE;

  assign occ_o.full     = (count_o == depth);
  assign occ_o.half     = ({count_o, 1'b0} >= {1'b0, depth});
  assign occ_o.nonempty = (count_o != `CTEFQ_CNT_ZERO);

  assign do_push = push_i & ~occ_o.full;
  assign do_pop  = pop_i & occ_o.nonempty;

  // pointers wrap at the configured depth, not at the index width
  assign next_head = (head_o == depth_code_i) ? `CTEFQ_IDX_ZERO
                                              : head_o + `CTEFQ_IDX_ONE;
  assign next_tail = (tail_o == depth_code_i) ? `CTEFQ_IDX_ZERO
                                              : tail_o + `CTEFQ_IDX_ONE;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      head_o <= `CTEFQ_IDX_ZERO;
    end
    else if (flush_i)
    begin
      head_o <= `CTEFQ_IDX_ZERO;
    end
    else if (do_push)
    begin
      head_o <= next_head;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tail_o <= `CTEFQ_IDX_ZERO;
    end
    else if (flush_i)
    begin
      tail_o <= `CTEFQ_IDX_ZERO;
    end
    else if (do_pop)
    begin
      tail_o <= next_tail;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_o <= `CTEFQ_CNT_ZERO;
    end
    else if (flush_i)
    begin
      count_o <= `CTEFQ_CNT_ZERO;
    end
    else if (do_push && !do_pop)
    begin
      count_o <= count_o + `CTEFQ_CNT_ONE;
    end
    else if (do_pop && !do_push)
    begin
      count_o <= count_o - `CTEFQ_CNT_ONE;
    end
  end

endmodule : ctefq_ptr

//--- ctefq_ctrl_props.sv
// concurrent checks on the ports of the event queue control block
// assumes one clock domain; bound into ctefq_ctrl below
`timescale 1ns/1ps

module ctefq_ctrl_props (
  // clock and reset
  input wire logic                  sys_clk_i,
  input wire logic                  arst_n_i,
  // register port
  input wire logic [7:0]            reg_addr_i,
  input wire logic [31:0]           reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [31:0]           reg_rdata_o,
  // mode and events
  input wire logic [2:0]            operating_mode_select_i,
  input wire logic                  event_req_i,
  input wire ctefq_pkg::ctefq_evt_t evt_wr_o,
  input wire logic [4:0]            event_read_pointer_o,
  input wire logic                  stamp_enable_o,
  input wire logic                  queue_flush_o,
  input wire logic                  irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  wire ctl_wr = reg_wr_i && reg_addr_i == 8'h00;
  wire cfg_wr = ctl_wr && operating_mode_select_i == 3'h4;

  sequence s_quiet;
    !reg_wr_i ##1 !reg_wr_i;
  endsequence
  sequence s_no_cfg;
    !cfg_wr ##1 !cfg_wr;
  endsequence

  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_ctl_holes: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
    (reg_rdata_o & 32'he0ff_fbd0) == 32'h0) // bit 8 too
    else $error("control read shows unimplemented bits");
  a_sta_holes: assert property (reg_rd_i && reg_addr_i == 8'h04 |=>
    reg_rdata_o[31:4] == 28'h0)
    else $error("status read shows upper bits");
  a_map_hole: assert property (reg_rd_i && reg_addr_i > 8'h08 |=>
    reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_evt_cause: assert property (!event_req_i |=> !evt_wr_o.valid)
    else $error("event written without request");
  a_stamp_tag: assert property (evt_wr_o.valid |->
    evt_wr_o.stamp == stamp_enable_o)
    else $error("event stamp differs from stamp enable");
  a_stamp_lock: assert property (s_no_cfg |=> $stable(stamp_enable_o))
    else $error("stamp enable moved outside configuration");
  a_flush_done: assert property (
    operating_mode_select_i != 3'h4 && !ctl_wr |-> ##2 !queue_flush_o)
    else $error("flush bit not cleared outside configuration");
  a_tail_quiet: assert property (
    s_quiet |=> ##1 $stable(event_read_pointer_o))
    else $error("tail moved without a register write");
  a_irq_mask: assert property (
    ctl_wr && reg_wdata_i[3:0] == 4'h0 |-> ##2 !irq_o)
    else $error("interrupt high with all enables cleared");
endmodule : ctefq_ctrl_props

bind ctefq_ctrl ctefq_ctrl_props ctefq_ctrl_props_i (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .operating_mode_select_i(operating_mode_select_i),
  .event_req_i(event_req_i), .evt_wr_o(evt_wr_o),
  .event_read_pointer_o(event_read_pointer_o),
  .stamp_enable_o(stamp_enable_o), .queue_flush_o(queue_flush_o),
  .irq_o(irq_o)
);

//--- ctefq_ctrl_tb.sv
// self-checking bench for the event queue control block
// drives every input of ctefq_ctrl itself; no partner model
`timescale 1ns/1ps

module ctefq_ctrl_tb;
  logic                  sys_clk      = 1'b0;
  logic                  arst_n       = 1'b0;
  logic [7:0]            reg_addr     = 8'h00;
  logic [31:0]           reg_wdata    = 32'h0;
  logic                  reg_wr       = 1'b0;
  logic                  reg_rd       = 1'b0;
  logic [2:0]            mode         = 3'h4;
  logic                  event_req    = 1'b0;
  logic [31:0]           reg_rdata;
  ctefq_pkg::ctefq_evt_t evt_wr;
  ctefq_pkg::ctefq_evt_t evt_seen;
  logic [4:0]            rd_ptr;
  logic                  stamp_en;
  logic                  flush;
  logic                  irq;
  int                    fail_count   = 0;
  int                    total_checks = 0;
  int                    cycles       = 0;

  always #25 sys_clk = ~sys_clk;

  ctefq_ctrl ctefq_ctrl_i (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .operating_mode_select_i(mode),
    .event_req_i(event_req), .evt_wr_o(evt_wr),
    .event_read_pointer_o(rd_ptr), .stamp_enable_o(stamp_en),
    .queue_flush_o(flush), .irq_o(irq)
  );

  task complete_run;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask : rd

  task rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk

  // n back-to-back events; keeps what the last one produced
  task push(input int n);
    event_req <= 1'b1;
    repeat (n) @(posedge sys_clk);
    event_req <= 1'b0;
    #1 evt_seen = evt_wr;
    @(posedge sys_clk);
  endtask : push

  // bounded poll, a stuck flush must not hang the run
  task wait_flush;
    logic [31:0] d;
    int          n;
    n = 0;
    d = 32'h0000_0400;
    while (d[10] && n < 20)
    begin
      rd(8'h00, d);
      n++;
    end
    chk(d[10], 1'b0);
  endtask : wait_flush

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rchk(8'h00, 32'h0000_0400);
    chk(flush, 1'b1);
    wr(8'h00, 32'h0300_002f);
    rchk(8'h00, 32'h0300_042f);
    chk(stamp_en, 1'b1);
    mode <= 3'h0;
    wait_flush;
    chk(flush, 1'b0);
    wr(8'h00, 32'h1f00_000f);
    rchk(8'h00, 32'h0300_002f);
    push(1);
    chk(evt_seen, 7'b1_00000_1);
    rchk(8'h04, 32'h1);
    rchk(8'h08, 32'h1);
    chk(irq, 1'b1);
    push(1);
    rchk(8'h04, 32'h3);
    push(2);
    chk(evt_seen, 7'b1_00011_1);
    rchk(8'h04, 32'h7);
    push(1);
    chk(evt_seen.valid, 1'b0);
    rchk(8'h04, 32'hf);
    wr(8'h04, 32'hffff_fff7);
    rchk(8'h04, 32'hf);
    wr(8'h04, 32'h8);
    rchk(8'h04, 32'h7);
    wr(8'h00, 32'h0000_010f);
    rchk(8'h04, 32'h3);
    chk(rd_ptr, 5'h01);
    rchk(8'h00, 32'h0300_002f);
    wr(8'h00, 32'h0);
    rchk(8'h08, 32'hf);
    chk(irq, 1'b0);
    wr(8'h08, 32'hf);
    rchk(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'hffff_ffff);
    rchk(8'h0c, 32'h0);
    wr(8'h00, 32'h0000_0401);
    wait_flush;
    rchk(8'h04, 32'h0);
    chk(rd_ptr, 5'h00);
    push(1);
    chk(evt_seen, 7'b1_00000_1);
    rchk(8'h08, 32'h1);
    chk(irq, 1'b1);
    mode <= 3'h4;
    wr(8'h00, 32'h1f00_0400);
    mode <= 3'h0;
    wait_flush;
    chk(stamp_en, 1'b0);
    push(15);
    rchk(8'h04, 32'h1);
    push(1);
    rchk(8'h04, 32'h3);
    push(16);
    chk(evt_seen, 7'b1_11111_0);
    rchk(8'h04, 32'h7);
    mode <= 3'h4;
    wr(8'h00, 32'h0000_0400);
    mode <= 3'h0;
    wait_flush;
    push(1);
    rchk(8'h04, 32'h7);
    complete_run;
  end
endmodule : ctefq_ctrl_tb
